// ==== src/rx_path_pkg.sv ====
// constants shared by the receive path control block
package rx_path_pkg;
  localparam int          CHANNELS_DEFAULT   = 14;
  localparam int          ADDR_W             = 8;
  localparam int          CLK_MHZ            = 20;
  localparam int          LINE_CLK_PERIOD_NS = 400;
  localparam int          MASTER_HALF_NS     = 200;
  localparam int          MASTER_HALF_CYCLES =
    (MASTER_HALF_NS * CLK_MHZ) / 1000;
  localparam int          LOS_HOLD_CYCLES    =
    (LINE_CLK_PERIOD_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0]  REG_POWER          = 8'h00;
  localparam logic [7:0]  REG_TERM           = 8'h04;
  localparam logic [7:0]  REG_GLOBAL         = 8'h08;
  localparam logic [7:0]  REG_OVERFLOW       = 8'h0c;
  localparam logic [7:0]  REG_LOS            = 8'h10;
  localparam logic [7:0]  REG_IRQ_STATUS     = 8'h14;
  localparam logic [7:0]  REG_IRQ_MASK       = 8'h18;
  localparam int          GBIT_HANDOFF       = 0;
  localparam int          GBIT_EDGE          = 1;
  localparam int          GBIT_SINGLE        = 2;
  localparam int          GBIT_OVF_MODE      = 3;
  localparam int          IRQ_LOS            = 0;
  localparam int          IRQ_VIOLATION      = 1;
  localparam int          IRQ_OVERFLOW       = 2;
  localparam logic [3:0]  GLOBAL_RESET       = 4'h0;
  localparam logic [2:0]  IRQ_RESET          = 3'h0;
endpackage

// ==== src/rx_channel.sv ====
// one receive channel: line sampling, clock output, data and indications
module rx_channel (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_line_clk,
  input  wire logic i_line_pos,
  input  wire logic i_line_neg,
  input  wire logic i_line_los,
  input  wire logic i_code_violation_flag,
  input  wire logic i_violation_counter_overflow,
  input  wire logic i_master_clk,
  input  wire logic i_power_on,
  input  wire logic i_edge_sel,
  input  wire logic i_single_rail,
  input  wire logic i_ovf_mode,
  input  wire logic i_ovf_clear,
  output logic      o_rx_clk,
  output logic      o_pos,
  output logic      o_neg,
  output logic      o_los,
  output logic      o_ovf,
  output logic      o_cv_event,
  output logic      o_ovf_set
);
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic       rx_clk;
    logic       pos;
    logic       neg;
    logic       los;
    logic       cv_pend;
    logic       ovf;
    logic       cv_event;
    logic       ovf_set;
  } chan_t;

  chan_t st;
  chan_t next_st;
  logic  use_master;
  logic  update;
  logic  violation;

  always_comb begin
    next_st = st;
    next_st.s1 = {i_violation_counter_overflow, i_code_violation_flag,
                  i_line_los, i_line_neg, i_line_pos, i_line_clk};
    next_st.s2 = st.s1;
    // lost signal or receiver off: fall back to master timing
    use_master = ~i_power_on | st.s2[3];
    // recovered clock follows the sampled line clock
    next_st.rx_clk = use_master ? i_master_clk : st.s2[0];
    // data moves only on the globally selected edge
    update = i_edge_sel ? (st.rx_clk & ~next_st.rx_clk)
                        : (~st.rx_clk & next_st.rx_clk);
    next_st.los = st.s2[3];
    // violations between two edges are remembered so none is missed
    next_st.cv_pend = (st.cv_pend | st.s2[4]) & i_power_on;
    // saturation sets, clear only drops it when no new set
    next_st.ovf = st.s2[5] | (st.ovf & ~i_ovf_clear);
    next_st.ovf_set = st.s2[5] & ~st.ovf;
    next_st.cv_event = 1'b0;
    violation = st.cv_pend | st.s2[4];
    if (update) begin
      next_st.cv_pend = 1'b0;
      next_st.cv_event = violation & i_power_on;
      if (!i_power_on) begin
        next_st.pos = 1'b0;
        next_st.neg = 1'b0;
      end else if (i_single_rail) begin
        next_st.pos = st.s2[1] | st.s2[2];
        // violation held for a full clock, overflow until reset
        next_st.neg = i_ovf_mode ? next_st.ovf : violation;
      end else begin
        next_st.pos = st.s2[1];
        next_st.neg = st.s2[2];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_rx_clk   = st.rx_clk;
  assign o_pos      = st.pos;
  assign o_neg      = st.neg;
  assign o_los      = st.los;
  assign o_ovf      = st.ovf;
  assign o_cv_event = st.cv_event;
  assign o_ovf_set  = st.ovf_set;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  property p_clk_recovered;
    (i_power_on && !st.s2[3]) |=> (o_rx_clk == $past(st.s2[0]));
  endproperty
  a_clk_recovered: assert property (p_clk_recovered)
    else $error("receive clock not following line clock");

  property p_clk_master;
    (!i_power_on || st.s2[3]) |=> (o_rx_clk == $past(i_master_clk));
  endproperty
  a_clk_master: assert property (p_clk_master)
    else $error("receive clock not on master timing");

  property p_edge;
    $changed(o_pos) |->
      ($past(i_edge_sel) ? $fell(o_rx_clk) : $rose(o_rx_clk));
  endproperty
  a_edge: assert property (p_edge)
    else $error("data changed off the selected edge");

  property p_dual_pos;
    (update && i_power_on && !i_single_rail) |=>
      (o_pos == $past(st.s2[1]) && o_neg == $past(st.s2[2]));
  endproperty
  a_dual_pos: assert property (p_dual_pos)
    else $error("dual rail data wrong");

  property p_nrz;
    (update && i_power_on && i_single_rail) |=>
      (o_pos == ($past(st.s2[1]) | $past(st.s2[2])));
  endproperty
  a_nrz: assert property (p_nrz)
    else $error("single rail data wrong");

  property p_ovf_hold;
    (st.ovf && !i_ovf_clear) |=> st.ovf;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold)
    else $error("overflow dropped before counter reset");

  c_violation: cover property (i_single_rail && $rose(o_neg));
endmodule

// ==== src/receive_path_control.sv ====
// receive path control: power, termination, loss summary, apb registers
// What this block does
// - all receivers start powered off after reset
// - with power pin high, each receiver follows its register bit
// - with power pin low, every receiver is forced off
// - after reset no termination is engaged, inputs are high impedance
// - per-channel register bits select termination by default
// - handoff bit set to one gives termination control to the pin
// - under pin control, high engages termination, low leaves it off
// - summary loss output rises on any channel loss, held one line clock
// - summary loss output stays high while any loss persists
// - each channel outputs a clock recovered from its line
// - absent signal or power pin low: clock runs from master timing
// - data changes on one global selected clock edge for all channels
// - dual rail: positive output carries positive pulse data
// - single rail: positive output carries decoded nrz data
// - dual rail: negative output carries negative pulse data
// - single rail violation mode: negative flags violations a clock
// - single rail overflow mode: negative high until counter reset
module receive_path_control #(
  parameter int CHANNELS = rx_path_pkg::CHANNELS_DEFAULT
) (
  input  wire logic                             i_clk,
  input  wire logic                             i_reset,
  input  wire logic                             i_psel,
  input  wire logic                             i_penable,
  input  wire logic                             i_pwrite,
  input  wire logic [rx_path_pkg::ADDR_W-1:0]   i_paddr,
  input  wire logic [31:0]                      i_pwdata,
  output logic      [31:0]                      o_prdata,
  output logic                                  o_pready,
  output logic                                  o_pslverr,
  input  wire logic                             i_receiver_power_pin,
  input  wire logic                             i_rx_termination_pin,
  input  wire logic [CHANNELS-1:0]              i_line_clk,
  input  wire logic [CHANNELS-1:0]              i_line_pos,
  input  wire logic [CHANNELS-1:0]              i_line_neg,
  input  wire logic [CHANNELS-1:0]              i_line_los,
  input  wire logic [CHANNELS-1:0]              i_code_violation_flag,
  input  wire logic [CHANNELS-1:0]              i_violation_counter_overflow,
  output logic      [CHANNELS-1:0]              o_rx_clk,
  output logic      [CHANNELS-1:0]              o_receive_positive_data,
  output logic      [CHANNELS-1:0]              o_receive_negative_data,
  output logic      [CHANNELS-1:0]              o_rx_power_on,
  output logic      [CHANNELS-1:0]              o_termination_on,
  output logic                                  o_loss_of_signal_summary,
  output logic                                  o_irq
);
  typedef struct packed {
    logic [1:0]          power_pin_sync;
    logic [1:0]          term_pin_sync;
    logic [CHANNELS-1:0] power_bits;
    logic [CHANNELS-1:0] term_bits;
    logic [CHANNELS-1:0] ovf_clear;
    logic [3:0]          global_ctrl;
    logic [2:0]          irq_status;
    logic [2:0]          irq_mask;
    logic [7:0]          mclk_cnt;
    logic                master_clk;
    logic [7:0]          hold_cnt;
    logic                los_out;
    logic [CHANNELS-1:0] rx_power;
    logic [CHANNELS-1:0] term_on;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                irq;
  } top_t;

  localparam logic [7:0] MCLK_LAST =
    8'(rx_path_pkg::MASTER_HALF_CYCLES - 1);
  localparam logic [7:0] HOLD_LAST =
    8'(rx_path_pkg::LOS_HOLD_CYCLES - 1);

  top_t                st;
  top_t                next_st;
  logic [CHANNELS-1:0] ch_los;
  logic [CHANNELS-1:0] ch_ovf;
  logic [CHANNELS-1:0] ch_cv_event;
  logic [CHANNELS-1:0] ch_ovf_set;
  logic                any_los;
  logic                wr_done;
  logic [2:0]          irq_set;
  logic [31:0]         rd_word;
  logic                rd_hit;

  assign any_los = |ch_los;

  // the transfer completes at the access edge; pready is one cycle wide
  assign wr_done = i_psel & i_penable & st.pready & i_pwrite;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (i_paddr)
      rx_path_pkg::REG_POWER:      rd_word[CHANNELS-1:0] = st.power_bits;
      rx_path_pkg::REG_TERM:       rd_word[CHANNELS-1:0] = st.term_bits;
      rx_path_pkg::REG_GLOBAL:     rd_word[3:0] = st.global_ctrl;
      rx_path_pkg::REG_OVERFLOW:   rd_word[CHANNELS-1:0] = ch_ovf;
      rx_path_pkg::REG_LOS:        rd_word[CHANNELS-1:0] = ch_los;
      rx_path_pkg::REG_IRQ_STATUS: rd_word[2:0] = st.irq_status;
      rx_path_pkg::REG_IRQ_MASK:   rd_word[2:0] = st.irq_mask;
      default:                     rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    next_st = st;
    // pins from outside: two flops before anything reads them
    next_st.power_pin_sync = {st.power_pin_sync[0], i_receiver_power_pin};
    next_st.term_pin_sync  = {st.term_pin_sync[0], i_rx_termination_pin};

    // apb slave: answer prepared during setup, shown in the access phase
    next_st.pready  = i_psel & ~i_penable & ~st.pready;
    next_st.pslverr = 1'b0;
    if (i_psel && !i_penable && !st.pready) begin
      next_st.prdata  = i_pwrite ? 32'h0000_0000 : rd_word;
      next_st.pslverr = ~rd_hit;
    end

    next_st.ovf_clear = '0;
    irq_set = 3'h0;
    irq_set[rx_path_pkg::IRQ_LOS]       = any_los & ~st.los_out;
    irq_set[rx_path_pkg::IRQ_VIOLATION] = |ch_cv_event;
    irq_set[rx_path_pkg::IRQ_OVERFLOW]  = |ch_ovf_set;
    next_st.irq_status = st.irq_status;

    if (wr_done) begin
      case (i_paddr)
        rx_path_pkg::REG_POWER:
          next_st.power_bits = i_pwdata[CHANNELS-1:0];
        rx_path_pkg::REG_TERM:
          next_st.term_bits = i_pwdata[CHANNELS-1:0];
        rx_path_pkg::REG_GLOBAL:
          next_st.global_ctrl = i_pwdata[3:0];
        rx_path_pkg::REG_OVERFLOW:
          next_st.ovf_clear = i_pwdata[CHANNELS-1:0];
        rx_path_pkg::REG_IRQ_STATUS:
          next_st.irq_status = st.irq_status & ~i_pwdata[2:0];
        rx_path_pkg::REG_IRQ_MASK:
          next_st.irq_mask = i_pwdata[2:0];
        default: begin
        end
      endcase
    end
    // a new event in the clearing cycle survives the clear
    next_st.irq_status = next_st.irq_status | irq_set;
    next_st.irq = |(next_st.irq_status & next_st.irq_mask);

    // effective receiver power: pin gates the per-channel bits
    if (st.power_pin_sync[1]) begin
      next_st.rx_power = st.power_bits;
    end else begin
      next_st.rx_power = '0;
    end

    // termination source: register bits unless handed to the pin
    if (!st.global_ctrl[rx_path_pkg::GBIT_HANDOFF]) begin
      next_st.term_on = st.term_bits;
    end else if (st.term_pin_sync[1]) begin
      next_st.term_on = '1;
    end else begin
      next_st.term_on = '0;
    end

    // internal master clock, free running from the system clock
    if (st.mclk_cnt == MCLK_LAST) begin
      next_st.mclk_cnt   = 8'h00;
      next_st.master_clk = ~st.master_clk;
    end else begin
      next_st.mclk_cnt = st.mclk_cnt + 8'h01;
    end

    // summary loss: held for at least one line clock period
    if (any_los) begin
      next_st.los_out  = 1'b1;
      next_st.hold_cnt = st.los_out ? st.hold_cnt : HOLD_LAST;
      if (st.los_out && st.hold_cnt != 8'h00) begin
        next_st.hold_cnt = st.hold_cnt - 8'h01;
      end
    end else if (st.los_out && st.hold_cnt != 8'h00) begin
      next_st.hold_cnt = st.hold_cnt - 8'h01;
    end else begin
      next_st.los_out  = 1'b0;
      next_st.hold_cnt = 8'h00;
    end
  end

  // reset leaves all receivers off and unterminated
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st             <= '0;
      st.global_ctrl <= rx_path_pkg::GLOBAL_RESET;
      st.irq_mask    <= rx_path_pkg::IRQ_RESET;
    end else begin
      st <= next_st;
    end
  end

  // channel slices: each samples its own line clock and power bit, all share the global settings
  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
    rx_channel u_ch (
      .i_clk                        (i_clk),
      .i_reset                      (i_reset),
      .i_line_clk                   (i_line_clk[c]),
      .i_line_pos                   (i_line_pos[c]),
      .i_line_neg                   (i_line_neg[c]),
      .i_line_los                   (i_line_los[c]),
      .i_code_violation_flag        (i_code_violation_flag[c]),
      .i_violation_counter_overflow (i_violation_counter_overflow[c]),
      .i_master_clk                 (st.master_clk),
      .i_power_on                   (st.rx_power[c]),
      .i_edge_sel     (st.global_ctrl[rx_path_pkg::GBIT_EDGE]),
      .i_single_rail  (st.global_ctrl[rx_path_pkg::GBIT_SINGLE]),
      .i_ovf_mode     (st.global_ctrl[rx_path_pkg::GBIT_OVF_MODE]),
      .i_ovf_clear                  (st.ovf_clear[c]),
      .o_rx_clk                     (o_rx_clk[c]),
      .o_pos                        (o_receive_positive_data[c]),
      .o_neg                        (o_receive_negative_data[c]),
      .o_los                        (ch_los[c]),
      .o_ovf                        (ch_ovf[c]),
      .o_cv_event                   (ch_cv_event[c]),
      .o_ovf_set                    (ch_ovf_set[c])
    );
  end

  assign o_prdata                 = st.prdata;
  assign o_pready                 = st.pready;
  assign o_pslverr                = st.pslverr;
  assign o_rx_power_on            = st.rx_power;
  assign o_termination_on         = st.term_on;
  assign o_loss_of_signal_summary = st.los_out;
  assign o_irq                    = st.irq;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  property p_power_reset;
    $past(i_reset) |-> (o_rx_power_on == '0);
  endproperty
  a_power_reset: assert property (p_power_reset)
    else $error("receiver powered after reset");

  property p_power_follow;
    st.power_pin_sync[1] |=> (o_rx_power_on == $past(st.power_bits));
  endproperty
  a_power_follow: assert property (p_power_follow)
    else $error("receiver power not following register");

  property p_power_forced_off;
    !st.power_pin_sync[1] |=> (o_rx_power_on == '0);
  endproperty
  a_power_forced_off: assert property (p_power_forced_off)
    else $error("receiver on while power pin low");

  property p_term_reset;
    $past(i_reset) |-> (o_termination_on == '0);
  endproperty
  a_term_reset: assert property (p_term_reset)
    else $error("termination engaged after reset");

  property p_term_reg;
    !st.global_ctrl[rx_path_pkg::GBIT_HANDOFF] |=>
      (o_termination_on == $past(st.term_bits));
  endproperty
  a_term_reg: assert property (p_term_reg)
    else $error("termination not from register bits");

  property p_term_pin;
    st.global_ctrl[rx_path_pkg::GBIT_HANDOFF] |=>
      (o_termination_on == {CHANNELS{$past(st.term_pin_sync[1])}});
  endproperty
  a_term_pin: assert property (p_term_pin)
    else $error("termination not from pin");

  property p_pin_ignored;
    (!st.global_ctrl[rx_path_pkg::GBIT_HANDOFF] &&
     !$past(st.global_ctrl[rx_path_pkg::GBIT_HANDOFF]) &&
     $stable(st.term_bits) && $changed(st.term_pin_sync[1])) |=>
      $stable(o_termination_on);
  endproperty
  a_pin_ignored: assert property (p_pin_ignored)
    else $error("termination pin acted without handoff");

  property p_los_min;
    $rose(o_loss_of_signal_summary) |-> o_loss_of_signal_summary[*8];
  endproperty
  a_los_min: assert property (p_los_min)
    else $error("loss summary shorter than one line clock");

  property p_los_follow;
    any_los |=> o_loss_of_signal_summary;
  endproperty
  a_los_follow: assert property (p_los_follow)
    else $error("loss summary low during loss");

  property p_los_clear;
    (!any_los && st.hold_cnt == 8'h00) |=> !o_loss_of_signal_summary;
  endproperty
  a_los_clear: assert property (p_los_clear)
    else $error("loss summary stuck after loss cleared");

  property p_power_write;
    (wr_done && i_paddr == rx_path_pkg::REG_POWER) |=>
      (st.power_bits == $past(i_pwdata[CHANNELS-1:0]));
  endproperty
  a_power_write: assert property (p_power_write)
    else $error("power register write lost");

  property p_term_write;
    (wr_done && i_paddr == rx_path_pkg::REG_TERM) |=>
      (st.term_bits == $past(i_pwdata[CHANNELS-1:0]));
  endproperty
  a_term_write: assert property (p_term_write)
    else $error("termination register write lost");

  property p_handoff_write;
    (wr_done && i_paddr == rx_path_pkg::REG_GLOBAL) |=>
      (st.global_ctrl == $past(i_pwdata[3:0]));
  endproperty
  a_handoff_write: assert property (p_handoff_write)
    else $error("handoff bit write lost");

  property p_pin_high;
    (st.global_ctrl[rx_path_pkg::GBIT_HANDOFF] && st.term_pin_sync[1]) |=>
      (&o_termination_on);
  endproperty
  a_pin_high: assert property (p_pin_high)
    else $error("pin high did not engage termination");

  // a held access phase must not look like a second answer
  property p_pready_pulse;
    o_pready |=> !o_pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse)
    else $error("pready longer than one cycle");

  property p_err_with_ready;
    o_pslverr |-> o_pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("pslverr without pready");

  c_los: cover property ($rose(o_loss_of_signal_summary));
  c_handoff: cover property (st.global_ctrl[rx_path_pkg::GBIT_HANDOFF]
                             && o_termination_on != '0);
  c_irq: cover property ($rose(o_irq));
  c_apb_err: cover property (o_pready && o_pslverr);
endmodule

// ==== testbench/framer_model.sv ====
// framer side model: finds receive clock rises and takes data on them
module framer_model (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_rx_clk,
  input  wire logic        i_rx_data,
  output logic      [15:0] o_rises,
  output logic             o_bit
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev;
  // sampled on the system clock, so a stopped receive clock adds nothing
  always @(posedge i_clk) begin
    if (i_reset) begin
      prev    <= 1'b0;
      o_rises <= 16'h0000;
      o_bit   <= 1'b0;
    end else begin
      prev <= i_rx_clk;
      if (i_rx_clk && !prev) begin
        o_rises <= o_rises + 16'h0001;
        o_bit   <= i_rx_data;
      end
    end
  end
endmodule

// ==== testbench/receive_path_control_tb.sv ====
// self-checking bench for the receive path control block
module receive_path_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0;
  logic        pwr = 1'b0, pin_pwr = 1'b1, pin_term = 1'b0;
  logic        lclk = 1'b0, run = 1'b0, tog = 1'b0, tog_en = 1'b0;
  logic        dp = 1'b0, dn = 1'b0, pready, pslverr, lss, irq, fbit, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [13:0] los = 14'h0, cv = 14'h0, ovf = 14'h0;
  logic [13:0] rclk, receive_positive_data, receive_negative_data, pon, ton;
  logic [15:0] rises;
  int          error_cnt = 0, check_count = 0, cyc = 0, lcnt = 0;

  always #25 clk = ~clk;
  // line clock of 400 ns made from system edges; it stands still when idle
  always @(posedge clk) begin
    lcnt <= (lcnt == 3) ? 0 : lcnt + 1;
    if (lcnt == 3) begin
      lclk <= run ? ~lclk : 1'b0;
      if (run && lclk && tog_en) tog <= ~tog;
    end
  end

  receive_path_control #(.CHANNELS(14)) receive_path_control_inst (
    .i_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_receiver_power_pin(pin_pwr), .i_rx_termination_pin(pin_term),
    .i_line_clk({14{lclk}}), .i_line_pos({14{dp ^ tog}}),
    .i_line_neg({14{dn}}), .i_line_los(los),
    .i_code_violation_flag(cv), .i_violation_counter_overflow(ovf),
    .o_rx_clk(rclk), .o_receive_positive_data(receive_positive_data),
    .o_receive_negative_data(receive_negative_data), .o_rx_power_on(pon),
    .o_termination_on(ton), .o_loss_of_signal_summary(lss), .o_irq(irq)
  );
  framer_model framer_model_inst (
    .i_clk(clk), .i_reset(rst), .i_rx_clk(rclk[0]), .i_rx_data(receive_positive_data[0]),
    .o_rises(rises), .o_bit(fbit)
  );

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one transfer; held until pready is seen at a rising edge, then released
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    chk("pready", pready, 1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rate(input string nm, input logic on);
    logic [15:0] r0;
    r0 = rises;
    cy(80);
    chk(nm, (rises - r0) > 16'd8, on);
  endtask

  task automatic t_reset;
    chk("power_on", pon, 0);
    chk("term_on", ton, 0);
    apb(0, rx_path_pkg::REG_POWER, 0);
    chk("power_reg", rd, 0);
    apb(0, 8'h40, 0);
    chk("unmapped_err", err, 1);
    $display("test reset done");
  endtask
  task automatic t_power;
    apb(1, rx_path_pkg::REG_POWER, 32'h3fff);
    cy(5);
    chk("power_all", pon, 14'h3fff);
    @(posedge clk);
    pin_pwr <= 1'b0;
    cy(5);
    chk("power_forced_off", pon, 0);
    @(posedge clk);
    pin_pwr <= 1'b1;
    apb(1, rx_path_pkg::REG_POWER, 32'h0005);
    cy(5);
    chk("power_some", pon, 14'h0005);
    $display("test power done");
  endtask
  task automatic t_term;
    @(posedge clk);
    pin_term <= 1'b1;
    apb(1, rx_path_pkg::REG_TERM, 32'h00a5);
    cy(5);
    chk("term_reg", ton, 14'h00a5);
    apb(1, rx_path_pkg::REG_GLOBAL, 32'h1);
    cy(5);
    chk("term_pin_high", ton, 14'h3fff);
    @(posedge clk);
    pin_term <= 1'b0;
    cy(5);
    chk("term_pin_low", ton, 0);
    apb(1, rx_path_pkg::REG_GLOBAL, 32'h0);
    cy(5);
    chk("term_back", ton, 14'h00a5);
    $display("test termination done");
  endtask
  task automatic t_los;
    int n;
    n = 0;
    @(posedge clk);
    los <= 14'h0008;
    @(posedge clk);
    los <= 14'h0;
    repeat (30) begin
      @(negedge clk);
      if (lss === 1'b1) n++;
    end
    chk("los_short_hold", n >= 8, 1);
    chk("los_released", lss, 0);
    chk("irq_masked", irq, 0);
    apb(0, rx_path_pkg::REG_IRQ_STATUS, 0);
    chk("los_event", rd[0], 1);
    apb(1, rx_path_pkg::REG_IRQ_MASK, 32'h1);
    cy(3);
    chk("irq_on", irq, 1);
    apb(1, rx_path_pkg::REG_IRQ_STATUS, 32'h1);
    cy(3);
    chk("irq_cleared", irq, 0);
    @(posedge clk);
    los <= 14'h2000;
    cy(40);
    chk("los_persists", lss, 1);
    apb(0, rx_path_pkg::REG_LOS, 0);
    chk("los_reg", rd, 32'h2000);
    @(posedge clk);
    los <= 14'h0;
    cy(20);
    chk("los_clears", lss, 0);
    $display("test loss done");
  endtask
  task automatic t_clock;
    apb(1, rx_path_pkg::REG_POWER, 32'h1);
    rate("clk_line_still", 0);
    @(posedge clk);
    run <= 1'b1;
    rate("clk_line_runs", 1);
    @(posedge clk);
    run <= 1'b0;
    los <= 14'h0001;
    rate("clk_master_los", 1);
    @(posedge clk);
    los <= 14'h0;
    pin_pwr <= 1'b0;
    rate("clk_master_pin", 1);
    @(posedge clk);
    pin_pwr <= 1'b1;
    run <= 1'b1;
    $display("test clock done");
  endtask
  task automatic t_data;
    @(posedge clk);
    dp <= 1'b1;
    cy(30);
    chk("dual_pos", receive_positive_data[1:0], 2'b01);
    chk("dual_neg_idle", receive_negative_data[0], 0);
    @(posedge clk);
    dp <= 1'b0;
    dn <= 1'b1;
    cy(30);
    chk("dual_pos_low", receive_positive_data[0], 0);
    chk("dual_neg", receive_negative_data[0], 1);
    apb(1, rx_path_pkg::REG_GLOBAL, 32'h4);
    cy(30);
    chk("single_nrz", receive_positive_data[0], 1);
    chk("framer_bit", fbit, 1);
    chk("no_violation", receive_negative_data[0], 0);
    @(posedge clk);
    cv <= 14'h0001;
    cy(30);
    chk("violation", receive_negative_data[0], 1);
    @(posedge clk);
    cv <= 14'h0;
    cy(30);
    chk("violation_gone", receive_negative_data[0], 0);
    apb(1, rx_path_pkg::REG_GLOBAL, 32'hc);
    @(posedge clk);
    ovf <= 14'h0001;
    @(posedge clk);
    ovf <= 14'h0;
    cy(60);
    chk("overflow_held", receive_negative_data[0], 1);
    apb(0, rx_path_pkg::REG_OVERFLOW, 0);
    chk("overflow_reg", rd[0], 1);
    apb(1, rx_path_pkg::REG_OVERFLOW, 32'h1);
    cy(30);
    chk("overflow_reset", receive_negative_data[0], 0);
    $display("test data done");
  endtask
  // data may move only in the cycle the receive clock takes the chosen edge
  task automatic t_edge;
    int ch;
    logic pc, pd;
    @(posedge clk);
    dn <= 1'b0;
    tog_en <= 1'b1;
    for (int e = 0; e < 2; e++) begin
      apb(1, rx_path_pkg::REG_GLOBAL, e * 2);
      cy(20);
      ch = 0;
      pc = rclk[0];
      pd = receive_positive_data[0];
      repeat (80) begin
        @(negedge clk);
        if (receive_positive_data[0] !== pd) begin
          ch++;
          chk("edge_kind", {pc, rclk[0]}, e ? 2'b10 : 2'b01);
        end
        pc = rclk[0];
        pd = receive_positive_data[0];
      end
      chk("edge_moves", ch > 4, 1);
    end
    $display("test edge done");
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_power();
    t_term();
    t_los();
    t_clock();
    t_data();
    t_edge();
    close_out();
  end
endmodule
